// ### hw/bsf_cfg.svh
// Purpose: constants for the buck switch and fault sequencer
// Assumes: 20 MHz core clock
// Notes: times are given in their own unit, cycle counts derive from them
// Functional notes
// - high side on each cycle start, off on peak trip, dead time, then low side
// - without external sync, cycles come from an internal 750kHz oscillator
// - lock to sync rising edges from the first pulse; source stays 500-1000kHz
// - no sync edge for four cycles reverts to internal oscillator without a gap
// - converter-on high starts a 5.5ms soft-start ramp, then full regulation
// - converter-on low holds shutdown: switches, drivers, reference, oscillator off
// - low supply lockout active keeps the converter from starting
// - regulation ok high only while enabled and output within 8.0 percent
// - 4-bit overcurrent counter sampled at cycle end, saturates at 1111 and 0000
// - counter at 1111 shuts switching off and resets the soft-start
// - after overcurrent shutdown wait 16 switching cycles, then restart with soft-start
// - overvoltage for 32 consecutive cycles shuts off and restarts soft-start
`ifndef BSF_CFG_SVH
`define BSF_CFG_SVH
`define BSF_CORE_CLK_KHZ 20000
`define BSF_OSC_KHZ 750
`define BSF_OSC_PERIOD_CYC (`BSF_CORE_CLK_KHZ / `BSF_OSC_KHZ)
`define BSF_SYNC_MIN_KHZ 500
`define BSF_SYNC_MAX_KHZ 1000
`define BSF_SYNC_MAX_PERIOD_CYC (`BSF_CORE_CLK_KHZ / `BSF_SYNC_MIN_KHZ)
`define BSF_SYNC_LOSS_PERIODS 4
`define BSF_SYNC_LOSS_CYC (`BSF_SYNC_LOSS_PERIODS * `BSF_OSC_PERIOD_CYC)
`define BSF_SS_TIME_US 5500
`define BSF_SS_CYCLES ((`BSF_SS_TIME_US * `BSF_OSC_KHZ) / 1000)
`define BSF_DEAD_TIME_NS 100
`define BSF_DEAD_CYC ((`BSF_DEAD_TIME_NS * `BSF_CORE_CLK_KHZ + 999999) / 1000000)
`define BSF_OC_MAX 4'hF
`define BSF_OC_RESTART_CYC 16
`define BSF_OV_LIMIT 32
`define BSF_SS_SHIFT 7
`endif

// ### hw/bsf_pkg.sv
// Purpose: types for the buck switch and fault sequencer
// Assumes: nothing
// Notes: one-hot codes for the sequencer and the switch phase
package bsf_pkg;
   typedef enum logic [3:0] {
      ST_OFF = 4'h1,
      ST_RAMP = 4'h2,
      ST_RUN = 4'h4,
      ST_FAULT = 4'h8
   } bsf_state_e;
   typedef enum logic [3:0] {
      PH_IDLE = 4'h1,
      PH_HS = 4'h2,
      PH_DT = 4'h4,
      PH_LS = 4'h8
   } bsf_phase_e;
   typedef struct packed {
      logic conv_on;
      logic low_supply_lockout;
      logic peak_trip;
      logic overcurrent;
      logic overvoltage;
      logic in_window;
      logic sync_clk;
   } bsf_pins_s;
   typedef struct packed {
      logic hs_on;
      logic ls_on;
   } bsf_drive_s;
endpackage

// ### hw/bsf_sequencer.sv
// Purpose: switch sequencing, clock selection, soft-start and fault handling
// Assumes: all pin inputs asynchronous; one 20 MHz clock
// Notes: switching cycle length comes from the internal oscillator or sync edges
`include "bsf_cfg.svh"
module bsf_sequencer #(
   parameter int SS_CYCLES = `BSF_SS_CYCLES
) (
   input wire logic i_core_clk,
   input wire logic i_srst,
   input wire bsf_pkg::bsf_pins_s i_pins,
   output bsf_pkg::bsf_drive_s o_drive,
   output logic o_regulation_ok_output,
   output logic o_osc_run,
   output logic o_ref_en,
   output logic o_ext_sync_active,
   output logic o_ss_active,
   output logic [3:0] o_oc_count
);
   localparam int OSC_W = 5;
   localparam int LOSS_W = 7;

   // three-stage pin filter
   logic [6:0] s1_q, s2_q, s3_q, stab_q, stab_d;
   bsf_pkg::bsf_pins_s pin;
   always_comb begin
      stab_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & stab_q);
   end
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         s1_q <= 7'h00;
         s2_q <= 7'h00;
         s3_q <= 7'h00;
         stab_q <= 7'h00;
      end else begin
         s1_q <= i_pins;
         s2_q <= s1_q;
         s3_q <= s2_q;
         stab_q <= stab_d;
      end
   end
   assign pin = stab_q;

   logic en;
   assign en = pin.conv_on & ~pin.low_supply_lockout;

   // clock selection
   logic [OSC_W-1:0] osc_q, osc_d;
   logic [LOSS_W-1:0] loss_q, loss_d;
   logic ext_q, ext_d, sprev_q, sprev_d;
   logic sync_edge, osc_wrap, cyc_start;
   // last measured sync period, slowest legal period until measured
   logic [5:0] per_q, per_d;
   logic miss, late;
   always_comb begin
      sync_edge = pin.sync_clk & ~sprev_q;
      osc_wrap = (osc_q == OSC_W'(`BSF_OSC_PERIOD_CYC - 1));
      // stand-in cycle when an expected sync edge is missing
      miss = ext_q & ~sync_edge & (loss_q == LOSS_W'(per_q) + LOSS_W'(1));
      late = ext_q & (loss_q > LOSS_W'(per_q) + LOSS_W'(1));
      sprev_d = pin.sync_clk;
      per_d = per_q;
      osc_d = osc_q;
      loss_d = loss_q;
      ext_d = ext_q;
      cyc_start = 1'b0;
      if (!en) begin
         osc_d = '0;
         loss_d = '0;
         ext_d = 1'b0;
         per_d = 6'(`BSF_SYNC_MAX_PERIOD_CYC);
      end else begin
         osc_d = osc_wrap ? '0 : osc_q + OSC_W'(1);
         if (sync_edge) begin
            // realign so a later fallback continues in phase
            osc_d = '0;
            loss_d = '0;
            ext_d = 1'b1;
            if (ext_q) begin
               per_d = (loss_q < LOSS_W'(`BSF_SYNC_MAX_PERIOD_CYC)) ? 6'(loss_q + LOSS_W'(1)) :
                  6'(`BSF_SYNC_MAX_PERIOD_CYC);
            end
         end else if (ext_q) begin
            if (miss) begin
               // later stand-ins follow the internal period
               osc_d = '0;
            end
            if (loss_q == LOSS_W'(`BSF_SYNC_LOSS_CYC - 1)) begin
               ext_d = 1'b0;
            end else begin
               loss_d = loss_q + LOSS_W'(1);
            end
         end
         cyc_start = sync_edge | miss | (osc_wrap & (~ext_q | late));
      end
   end
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         osc_q <= '0;
         loss_q <= '0;
         ext_q <= 1'b0;
         sprev_q <= 1'b0;
         per_q <= 6'(`BSF_SYNC_MAX_PERIOD_CYC);
      end else begin
         osc_q <= osc_d;
         loss_q <= loss_d;
         ext_q <= ext_d;
         sprev_q <= sprev_d;
         per_q <= per_d;
      end
   end

   // sequencer state
   bsf_pkg::bsf_state_e st_q, st_d;
   logic [12:0] ss_q, ss_d;
   logic [3:0] oc_q, oc_d, oc_nx;
   logic [5:0] ov_q, ov_d, ov_nx;
   logic [4:0] flt_q, flt_d;
   logic active, smp, oc_trip, ov_trip;
   always_comb begin
      active = (st_q == bsf_pkg::ST_RAMP) || (st_q == bsf_pkg::ST_RUN);
      smp = active & cyc_start;
      if (pin.overcurrent) begin
         oc_nx = (oc_q == `BSF_OC_MAX) ? oc_q : oc_q + 4'h1;
      end else begin
         oc_nx = (oc_q == 4'h0) ? oc_q : oc_q - 4'h1;
      end
      ov_nx = pin.overvoltage ? ov_q + 6'h01 : 6'h00;
      oc_trip = smp & (oc_nx == `BSF_OC_MAX);
      ov_trip = smp & (ov_nx == 6'(`BSF_OV_LIMIT));
      st_d = st_q;
      ss_d = ss_q;
      oc_d = oc_q;
      ov_d = ov_q;
      flt_d = flt_q;
      if (!en) begin
         st_d = bsf_pkg::ST_OFF;
         ss_d = '0;
         oc_d = '0;
         ov_d = '0;
         flt_d = '0;
      end else begin
         unique case (st_q)
            bsf_pkg::ST_OFF: begin
               st_d = bsf_pkg::ST_RAMP;
               ss_d = '0;
            end
            bsf_pkg::ST_RAMP, bsf_pkg::ST_RUN: begin
               if (smp) begin
                  oc_d = oc_nx;
                  ov_d = ov_nx;
               end
               if (oc_trip) begin
                  st_d = bsf_pkg::ST_FAULT;
                  ss_d = '0;
                  flt_d = '0;
               end else if (ov_trip) begin
                  st_d = bsf_pkg::ST_RAMP;
                  ss_d = '0;
                  ov_d = '0;
               end else if (st_q == bsf_pkg::ST_RAMP && smp) begin
                  if (ss_q == 13'(SS_CYCLES - 1)) begin
                     st_d = bsf_pkg::ST_RUN;
                  end else begin
                     ss_d = ss_q + 13'h0001;
                  end
               end
            end
            bsf_pkg::ST_FAULT: begin
               if (cyc_start) begin
                  if (flt_q == 5'(`BSF_OC_RESTART_CYC - 1)) begin
                     st_d = bsf_pkg::ST_RAMP;
                     ss_d = '0;
                     oc_d = '0;
                     ov_d = '0;
                  end else begin
                     flt_d = flt_q + 5'h01;
                  end
               end
            end
            default: begin
               st_d = bsf_pkg::ST_OFF;
            end
         endcase
      end
   end
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         st_q <= bsf_pkg::ST_OFF;
         ss_q <= '0;
         oc_q <= '0;
         ov_q <= '0;
         flt_q <= '0;
      end else begin
         st_q <= st_d;
         ss_q <= ss_d;
         oc_q <= oc_d;
         ov_q <= ov_d;
         flt_q <= flt_d;
      end
   end

   // switch phase within a cycle
   bsf_pkg::bsf_phase_e ph_q, ph_d;
   logic [4:0] ont_q, ont_d, lim;
   logic [1:0] dt_q, dt_d;
   always_comb begin
      // soft-start caps the high-side on-time as the ramp advances
      lim = ss_q[`BSF_SS_SHIFT +: 5] + 5'h01;
      ph_d = ph_q;
      ont_d = ont_q;
      dt_d = dt_q;
      if (!en || !active || oc_trip || ov_trip) begin
         ph_d = bsf_pkg::PH_IDLE;
         ont_d = '0;
         dt_d = '0;
      end else if (cyc_start && st_d != bsf_pkg::ST_FAULT) begin
         ph_d = bsf_pkg::PH_HS;
         ont_d = '0;
      end else begin
         unique case (ph_q)
            bsf_pkg::PH_IDLE: ph_d = bsf_pkg::PH_IDLE;
            bsf_pkg::PH_HS: begin
               ont_d = (ont_q == 5'h1F) ? ont_q : ont_q + 5'h01;
               if (pin.peak_trip || (st_q == bsf_pkg::ST_RAMP && ont_q >= lim)) begin
                  ph_d = bsf_pkg::PH_DT;
                  dt_d = '0;
               end
            end
            bsf_pkg::PH_DT: begin
               if (dt_q == 2'(`BSF_DEAD_CYC - 1)) begin
                  ph_d = bsf_pkg::PH_LS;
               end else begin
                  dt_d = dt_q + 2'h1;
               end
            end
            bsf_pkg::PH_LS: ph_d = bsf_pkg::PH_LS;
            default: ph_d = bsf_pkg::PH_IDLE;
         endcase
      end
   end
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         ph_q <= bsf_pkg::PH_IDLE;
         ont_q <= '0;
         dt_q <= '0;
      end else begin
         ph_q <= ph_d;
         ont_q <= ont_d;
         dt_q <= dt_d;
      end
   end

   // registered outputs
   bsf_pkg::bsf_drive_s drv_q, drv_d;
   logic pg_q, pg_d;
   always_comb begin
      drv_d.hs_on = (ph_d == bsf_pkg::PH_HS);
      drv_d.ls_on = (ph_d == bsf_pkg::PH_LS);
      pg_d = en & (st_d != bsf_pkg::ST_OFF) & pin.in_window;
   end
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         drv_q <= '0;
         pg_q <= 1'b0;
      end else begin
         drv_q <= drv_d;
         pg_q <= pg_d;
      end
   end

   assign o_drive = drv_q;
   assign o_regulation_ok_output = pg_q;
   assign o_osc_run = (st_q != bsf_pkg::ST_OFF);
   assign o_ref_en = (st_q != bsf_pkg::ST_OFF);
   assign o_ext_sync_active = ext_q;
   assign o_ss_active = (st_q == bsf_pkg::ST_RAMP);
   assign o_oc_count = oc_q;
endmodule // bsf_sequencer

// ### tb/bsf_props.sv
// Purpose: port checker for the switch sequencer
// Assumes: one clock, synchronous reset
// Notes: bound onto bsf_sequencer
module bsf_props (
   input wire logic i_core_clk,
   input wire logic i_srst,
   input wire bsf_pkg::bsf_pins_s i_pins,
   input wire bsf_pkg::bsf_drive_s o_drive,
   input wire logic o_regulation_ok_output,
   input wire logic o_osc_run,
   input wire logic o_ref_en,
   input wire logic o_ext_sync_active,
   input wire logic o_ss_active,
   input wire logic [3:0] o_oc_count
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_srst);
   sequence s_full;
      $rose(o_oc_count == 4'hF);
   endsequence
   sequence s_wait;
      ##300 (o_oc_count == 4'hF) ##[70:160] (o_oc_count == 4'h0);
   endsequence
   a_no_overlap: assert property (!(o_drive.hs_on && o_drive.ls_on)) else $error("overlap");
   a_dead_gap: assert property ($fell(o_drive.hs_on) |-> !o_drive.ls_on [*2]) else $error("dead time");
   a_off_quiet: assert property (!o_osc_run |-> o_drive == 2'h0 && !o_regulation_ok_output)
      else $error("active in shutdown");
   a_ref_follow: assert property (o_ref_en == o_osc_run) else $error("reference");
   a_oc_clear: assert property (!o_osc_run |-> o_oc_count == 4'h0) else $error("count kept");
   a_oc_step: assert property ($changed(o_oc_count) && o_osc_run && $past(o_oc_count) != 4'hF |->
      o_oc_count == $past(o_oc_count) + 4'h1 || o_oc_count + 4'h1 == $past(o_oc_count)) else $error("count jump");
   a_fault_off: assert property (s_full |=> o_drive == 2'h0 && !o_ss_active) else $error("fault on");
   a_fault_wait: assert property (s_full |-> s_wait) else $error("restart wait");
endmodule // bsf_props
bind bsf_sequencer bsf_props u_props (.i_core_clk(i_core_clk), .i_srst(i_srst), .i_pins(i_pins),
   .o_drive(o_drive), .o_regulation_ok_output(o_regulation_ok_output), .o_osc_run(o_osc_run),
   .o_ref_en(o_ref_en), .o_ext_sync_active(o_ext_sync_active), .o_ss_active(o_ss_active),
   .o_oc_count(o_oc_count));

// ### tb/bsf_front_model.sv
// Purpose: sync clock source and peak comparator
// Assumes: 833 kHz source, free phase
// Notes: clock stands low while off
module bsf_front_model (
   input wire logic i_core_clk,
   input wire logic i_hs_on,
   input wire logic i_sync_en,
   output logic o_peak_trip,
   output logic o_sync_clk
);
   timeunit 1ns;
   timeprecision 1ns;
   int on_q = 0;
   assign o_peak_trip = on_q >= 6;
   always @(posedge i_core_clk) on_q <= i_hs_on ? on_q + 1 : 0;
   initial begin
      o_sync_clk = 1'b0;
      #17;
      forever #600 o_sync_clk = i_sync_en ? ~o_sync_clk : 1'b0;
   end
endmodule // bsf_front_model

// ### tb/buck_switch_fault_sequencer_test.sv
// Purpose: self-checking bench for the switch sequencer
// Assumes: soft-start cut to 8 cycles
// Notes: inputs change at the falling edge
module buck_switch_fault_sequencer_test;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int SS = 8;
   logic clk = 1'b0, srst = 1'b1, en = 1'b0, lock = 1'b0, oc = 1'b0, ov = 1'b0, win = 1'b0, sen = 1'b0;
   logic trip, sync, pg, osc, ref_en, ext, ss;
   logic [3:0] occ;
   bsf_pkg::bsf_drive_s drv;
   int bad_count = 0, check_count = 0, cyc = 0, n, p;
   bsf_sequencer #(.SS_CYCLES(SS)) dut (.i_core_clk(clk), .i_srst(srst), .i_pins({en, lock, trip, oc, ov, win, sync}),
      .o_drive(drv), .o_regulation_ok_output(pg), .o_osc_run(osc), .o_ref_en(ref_en),
      .o_ext_sync_active(ext), .o_ss_active(ss), .o_oc_count(occ));
   bsf_front_model model (.i_core_clk(clk), .i_hs_on(drv.hs_on), .i_sync_en(sen), .o_peak_trip(trip),
      .o_sync_clk(sync));
   initial forever #25 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         complete_run();
      end
   end
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   function automatic logic [3:0] val(input int w);
      case (w)
         0: return occ;
         1: return {3'h0, ss};
         2: return {3'h0, ext};
         3: return {3'h0, pg};
         default: return {3'h0, drv.hs_on};
      endcase
   endfunction
   // bounded wait for a watched output to reach a value
   task automatic wt(input int w, input logic [3:0] v, input int lim, output int k);
      k = 0;
      while (val(w) !== v && k < lim) begin
         @(negedge clk);
         k++;
      end
   endtask
   task automatic rise(output int k);
      wt(4, 4'h0, 99, k);
      wt(4, 4'h1, 99, p);
      k += p;
   endtask
   task automatic t_start();
      en = 1'b1;
      lock = 1'b1;
      repeat (20) @(negedge clk);
      chk("osc_run", osc, 16'h0);
      lock = 1'b0;
      wt(1, 4'h1, 20, n);
      chk("ss_active", ss, 16'h1);
      rise(n);
      rise(n);
      chk("osc period", n, 16'h1A);
      wt(1, 4'h0, SS * 26 + 200, n);
      chk("ramp length", n > 78, 16'h1);
      chk("reg ok", pg, 16'h1);
      win = 1'b0;
      wt(3, 4'h0, 10, n);
      chk("reg ok drop", pg, 16'h0);
      win = 1'b1;
   endtask
   task automatic t_sync();
      sen = 1'b1;
      wt(2, 4'h1, 80, n);
      rise(n);
      rise(n);
      chk("sync period", n, 16'h18);
      sen = 1'b0;
      repeat (8) begin
         rise(n);
         chk("no gap", n < 27, 16'h1);
      end
      chk("ext drop", ext, 16'h0);
   endtask
   task automatic t_ov();
      ov = 1'b1;
      wt(1, 4'h1, 1200, n);
      chk("ov restart", n > 780 && n < 880, 16'h1);
      ov = 1'b0;
   endtask
   task automatic t_oc();
      oc = 1'b1;
      wt(0, 4'hF, 600, n);
      chk("oc full", occ, 16'hF);
      @(negedge clk);
      chk("fault drive", drv, 16'h0);
      oc = 1'b0;
      wt(0, 4'h0, 600, n);
      chk("restart wait", n > 350, 16'h1);
      chk("restart ramp", ss, 16'h1);
      oc = 1'b1;
      repeat (100) @(negedge clk);
      oc = 1'b0;
      repeat (60) @(negedge clk);
      en = 1'b0;
      repeat (8) @(negedge clk);
      chk("shutdown", {occ, drv, osc, ref_en, pg}, 16'h0);
   endtask
   initial begin
      repeat (6) @(negedge clk);
      srst = 1'b0;
      win = 1'b1;
      t_start();
      t_sync();
      t_ov();
      t_oc();
      complete_run();
   end
endmodule // buck_switch_fault_sequencer_test
